// ===== shared/slpc_map.vh
// constants for the sleep-mode controller
`ifndef SLPC_MAP_VH
`define SLPC_MAP_VH
`define SLPC_K_IDLE 3'h0
`define SLPC_K_ADCNR 3'h1
`define SLPC_K_PDOWN 3'h2
`define SLPC_K_PSAVE 3'h3
`define SLPC_K_STBY 3'h6
`define SLPC_CLK_NS 5
`define SLPC_STBY_WAKE_CK 16'h0006
`define SLPC_IRQ_HALT_CK 16'h0004
`define SLPC_CNT_W 16
`define SLPC_CNT_ONE 16'h0001
`define SLPC_CNT_ZERO 16'h0000
`define SLPC_DEF_OSC_START 16'h0006
`endif

// ===== hw/slpc_sleep_ctrl.v
// sleep-mode controller: mode decode, clock gating, wake qualification
`timescale 1ns/1ps
`include "slpc_map.vh"
// What this block does
// - decode three-bit field, three codes reserved
// - idle stops core and flash clocks, and timer oscillator unless async timer selected
// - idle wakes on any enabled interrupt
// - idle or adc-quiet starts adc conversion
// - adc-quiet also stops io clock
// - adc-quiet wakes only on listed sources
// - power-down stops oscillator and generated clocks
// - power-down wakes on reset, address, level
// - power-down wake waits fuse-set restart delay
// - power-save keeps async timer when selected
// - power-save wakes on enabled timer2 events
// - standby needs crystal, keeps main oscillator
// - standby resumes six cycles after wake
// - sleep only when arm bit set
// - interrupt wake halts four extra cycles
// - reset during sleep wakes to vector
module slpc_sleep_ctrl (
  input wire clk, // 200 MHz clock
  input wire arst_n, // async reset, active low
  input wire sleep_exec, // core executes sleep instruction, pulse
  input wire sleep_arm_bit, // arm bit from control register
  input wire [2:0] sleep_kind_field, // mode select field
  input wire xtal_selected, // crystal/resonator clock option chosen
  input wire [15:0] osc_start_cycles, // restart delay from clock fuses
  input wire adc_enabled, // adc is enabled
  input wire timer2_async_select, // timer 2 on async clock
  input wire global_irq_en, // global interrupt enable
  input wire irq_pending_any, // any enabled interrupt pending
  input wire adc_done_irq, // adc conversion complete
  input wire ext_irq_line_a, // level interrupt a, pin
  input wire ext_irq_line_b, // level interrupt b, pin
  input wire ext_level_en, // level interrupts enabled
  input wire two_wire_addr_hit, // address match interrupt
  input wire timer2_irq, // timer 2 interrupt (enabled)
  input wire timer2_ovf_ev, // timer 2 overflow event
  input wire timer2_cmp_ev, // timer 2 compare event
  input wire timer2_ovf_ie, // timer 2 overflow enable
  input wire timer2_cmp_ie, // timer 2 compare enable
  input wire store_ready_irq, // program-store or eeprom ready
  input wire wake_reset, // external, watchdog or brown-out reset
  output reg clk_core_en, // core clock enable
  output reg clk_flash_en, // flash clock enable
  output reg clk_io_en, // io clock enable
  output reg clk_adc_en, // adc clock enable
  output reg clk_async_en, // async timer clock enable
  output reg main_osc_en, // main oscillator enable
  output reg timer_osc_en, // timer oscillator enable
  output reg adc_start, // start adc conversion, pulse
  output reg asleep, // controller is in a sleep mode
  output reg reset_vector, // resume at reset vector, pulse
  output reg irq_resume // resume into interrupt routine, pulse
);
  localparam ST_RUN = 4'h1;
  localparam ST_SLEEP = 4'h2;
  localparam ST_WAIT = 4'h4;
  localparam ST_HALT = 4'h8;

  reg [3:0] st_q, st_d;
  reg [2:0] mode_q, mode_d;
  reg [15:0] cnt_q, cnt_d;
  reg by_irq_q, by_irq_d;
  reg rst_q, rst_d;
  reg la_s1_q, la_s2_q, lb_s1_q, lb_s2_q;
  reg wake_irq;
  reg wake_any;
  wire kind_ok;
  wire enter;

  // returns 1 for a usable mode code; reserved codes and crystal-less
  // standby fall through to "no sleep"
  function kind_valid;
    input [2:0] k;
    input xt;
    begin
      case (k)
        `SLPC_K_IDLE, `SLPC_K_ADCNR, `SLPC_K_PDOWN, `SLPC_K_PSAVE:
          kind_valid = 1'b1;
        `SLPC_K_STBY: kind_valid = xt;
        default: kind_valid = 1'b0;
      endcase
    end
  endfunction

  assign kind_ok = kind_valid(sleep_kind_field, xtal_selected);
  // a sleep op seen while asleep or waking must not retrigger adc_start
  assign enter = sleep_exec & sleep_arm_bit & kind_ok &
    (st_q == ST_RUN);

  // level lines come from pins; partner keeps level long enough
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      la_s1_q <= 1'b0;
      la_s2_q <= 1'b0;
      lb_s1_q <= 1'b0;
      lb_s2_q <= 1'b0;
    end else begin
      la_s1_q <= ext_irq_line_a;
      la_s2_q <= la_s1_q;
      lb_s1_q <= ext_irq_line_b;
      lb_s2_q <= lb_s1_q;
    end
  end

  always @* begin
    wake_irq = 1'b0;
    case (mode_q)
      `SLPC_K_IDLE: wake_irq = irq_pending_any;
      `SLPC_K_ADCNR: wake_irq = adc_done_irq | two_wire_addr_hit |
        timer2_irq | store_ready_irq |
        (ext_level_en & (la_s2_q | lb_s2_q));
      `SLPC_K_PSAVE: wake_irq = two_wire_addr_hit |
        (ext_level_en & (la_s2_q | lb_s2_q)) |
        (timer2_async_select & global_irq_en &
        ((timer2_ovf_ev & timer2_ovf_ie) |
        (timer2_cmp_ev & timer2_cmp_ie)));
      default: wake_irq = two_wire_addr_hit |
        (ext_level_en & (la_s2_q | lb_s2_q));
    endcase
    wake_any = wake_irq | wake_reset;
  end

  always @* begin
    st_d = st_q;
    mode_d = mode_q;
    cnt_d = cnt_q;
    by_irq_d = by_irq_q;
    rst_d = 1'b0;
    case (st_q)
      ST_RUN: begin
        if (enter) begin
          st_d = ST_SLEEP;
          mode_d = sleep_kind_field;
        end
      end
      ST_SLEEP: begin
        if (wake_any) begin
          by_irq_d = ~wake_reset;
          case (mode_q)
            `SLPC_K_IDLE, `SLPC_K_ADCNR: begin
              // oscillator never stopped: only the interrupt halt
              cnt_d = `SLPC_IRQ_HALT_CK;
              st_d = ST_HALT;
            end
            `SLPC_K_STBY: begin
              cnt_d = `SLPC_STBY_WAKE_CK;
              st_d = ST_WAIT;
            end
            default: begin
              // zero delay from fuses still costs one cycle
              cnt_d = (osc_start_cycles == `SLPC_CNT_ZERO) ?
                `SLPC_CNT_ONE : osc_start_cycles;
              st_d = ST_WAIT;
            end
          endcase
        end
      end
      ST_WAIT: begin
        cnt_d = cnt_q - `SLPC_CNT_ONE;
        if (cnt_q == `SLPC_CNT_ONE) begin
          if (by_irq_q) begin
            cnt_d = `SLPC_IRQ_HALT_CK;
            st_d = ST_HALT;
          end else begin
            rst_d = 1'b1;
            st_d = ST_RUN;
          end
        end
      end
      ST_HALT: begin
        cnt_d = cnt_q - `SLPC_CNT_ONE;
        if (cnt_q == `SLPC_CNT_ONE) begin
          rst_d = ~by_irq_q;
          st_d = ST_RUN;
        end
      end
      default: st_d = ST_RUN;
    endcase
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_RUN;
      mode_q <= `SLPC_K_IDLE;
      cnt_q <= `SLPC_CNT_ZERO;
      by_irq_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      st_q <= st_d;
      mode_q <= mode_d;
      cnt_q <= cnt_d;
      by_irq_q <= by_irq_d;
      rst_q <= rst_d;
    end
  end

  // clock enables registered so gating never glitches
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_core_en <= 1'b1;
      clk_flash_en <= 1'b1;
      clk_io_en <= 1'b1;
      clk_adc_en <= 1'b1;
      clk_async_en <= 1'b1;
      main_osc_en <= 1'b1;
      timer_osc_en <= 1'b1;
      adc_start <= 1'b0;
      asleep <= 1'b0;
      reset_vector <= 1'b0;
      irq_resume <= 1'b0;
    end else begin
      asleep <= (st_d != ST_RUN);
      reset_vector <= rst_d;
      irq_resume <= (st_q == ST_HALT) && (st_d == ST_RUN) && by_irq_q;
      adc_start <= enter & adc_enabled &
        ((sleep_kind_field == `SLPC_K_IDLE) |
        (sleep_kind_field == `SLPC_K_ADCNR));
      // oscillator restarts at wake so it can settle during ST_WAIT
      if (st_d == ST_SLEEP) begin
        clk_core_en <= 1'b0;
        clk_flash_en <= 1'b0;
        clk_io_en <= (mode_d == `SLPC_K_IDLE);
        clk_adc_en <= (mode_d == `SLPC_K_IDLE) |
          (mode_d == `SLPC_K_ADCNR);
        clk_async_en <= (mode_d == `SLPC_K_IDLE) |
          (mode_d == `SLPC_K_ADCNR) |
          ((mode_d == `SLPC_K_PSAVE) & timer2_async_select);
        main_osc_en <= (mode_d == `SLPC_K_IDLE) |
          (mode_d == `SLPC_K_ADCNR) | (mode_d == `SLPC_K_STBY);
        timer_osc_en <= timer2_async_select &
          (mode_d != `SLPC_K_PDOWN) & (mode_d != `SLPC_K_STBY);
      end else begin
        clk_core_en <= (st_d == ST_RUN);
        clk_flash_en <= (st_d == ST_RUN);
        clk_io_en <= 1'b1;
        clk_adc_en <= 1'b1;
        clk_async_en <= 1'b1;
        main_osc_en <= 1'b1;
        timer_osc_en <= 1'b1;
      end
    end
  end
endmodule

// ===== dv/slpc_sleep_ctrl_asserts.sv
// port assertions for the sleep-mode controller
`timescale 1ns/1ps
module slpc_sleep_ctrl_chk (
  input wire clk, // clock
  input wire arst_n, // reset
  input wire sleep_exec, // sleep op
  input wire sleep_arm_bit, // arm
  input wire [2:0] sleep_kind_field, // mode
  input wire xtal_selected, // crystal
  input wire adc_enabled, // adc on
  input wire irq_pending_any, // irq
  input wire wake_reset, // reset src
  input wire clk_core_en, // core
  input wire clk_flash_en, // flash
  input wire clk_io_en, // io
  input wire clk_adc_en, // adc
  input wire main_osc_en, // osc
  input wire adc_start, // adc go
  input wire asleep, // sleeping
  input wire irq_resume, // to isr
  input wire reset_vector // to vector
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // while asleep every request is ignored, so only awake ones count
  wire req = sleep_exec && !asleep;
  wire go = req && sleep_arm_bit;
  wire [2:0] k = sleep_kind_field;
  sequence s_halt;
    !irq_resume [*4] ##1 irq_resume && clk_core_en;
  endsequence
  property p_idle;
    go && k == 3'h0 |=> asleep && !clk_core_en && !clk_flash_en &&
      clk_io_en && clk_adc_en;
  endproperty
  a_idle: assert property (p_idle) else $error("idle enables");
  property p_adcnr;
    go && k == 3'h1 |=> asleep && !clk_io_en && clk_adc_en && !clk_core_en;
  endproperty
  a_adcnr: assert property (p_adcnr) else $error("adc quiet");
  property p_pdown;
    go && k == 3'h2 |=> asleep && !main_osc_en && !clk_adc_en;
  endproperty
  a_pdown: assert property (p_pdown) else $error("power-down");
  property p_stby;
    go && k == 3'h6 && xtal_selected |=> asleep && main_osc_en && !clk_io_en;
  endproperty
  a_stby: assert property (p_stby) else $error("standby");
  property p_arm;
    req && !sleep_arm_bit |=> !asleep;
  endproperty
  a_arm: assert property (p_arm) else $error("slept unarmed");
  property p_resv;
    req && (k[2:1] == 2'b10 || (k == 3'h6 && !xtal_selected)) |=> !asleep;
  endproperty
  a_resv: assert property (p_resv) else $error("bad code slept");
  property p_adc;
    go && !k[2] && !k[1] |=> adc_start == adc_enabled;
  endproperty
  a_adc: assert property (p_adc) else $error("adc start");
  property p_wake;
    asleep && clk_io_en && clk_adc_en && !clk_core_en &&
      $rose(irq_pending_any) |=> s_halt;
  endproperty
  a_wake: assert property (p_wake) else $error("halt length");
  property p_rst;
    asleep && !clk_core_en && $rose(wake_reset) |-> ##[1:8] reset_vector;
  endproperty
  a_rst: assert property (p_rst) else $error("reset wake");
endmodule
bind slpc_sleep_ctrl slpc_sleep_ctrl_chk u_chk (.*);

// ===== dv/slpc_core_model.sv
// interrupt-system model: holds a wake request until it is served
`timescale 1ns/1ps
module slpc_core_model (
  input wire clk, // clock
  input wire arst_n, // reset
  input wire fire, // raise request
  input wire irq_resume, // request served
  output reg irq_pending_any
);
  // level held to service, so a slow restart still sees it
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      irq_pending_any <= 1'b0;
    else if (fire)
      irq_pending_any <= 1'b1;
    else if (irq_resume)
      irq_pending_any <= 1'b0;
  end
endmodule

// ===== dv/slpc_sleep_ctrl_tb.sv
// self-checking bench for the sleep-mode controller
`timescale 1ns/1ps
module slpc_sleep_ctrl_tb;
  reg clk = 1'b0;
  reg arst_n = 1'b0;
  reg sx = 1'b0, arm = 1'b0, xt = 1'b1, adc = 1'b1, gie = 1'b1;
  reg as2 = 1'b1;
  reg [2:0] kind = 3'h0;
  reg [15:0] osc = 16'h0003;
  reg fire = 1'b0, lva = 1'b0, lven = 1'b1, ovf = 1'b0, wrst = 1'b0;
  wire ce, fe, ie, ae, ye, me, te, ast, slp, rv, ir, irq;
  integer fail_count = 0, checks = 0, cyc = 0, i, n;
  reg [2:0] km [0:4];
  reg [6:0] ev [0:4];
  always #2.5 clk = ~clk;
  slpc_core_model u_core (.clk(clk), .arst_n(arst_n), .fire(fire),
    .irq_resume(ir), .irq_pending_any(irq));
  slpc_sleep_ctrl DUT (.clk(clk), .arst_n(arst_n), .sleep_exec(sx),
    .sleep_arm_bit(arm), .sleep_kind_field(kind), .xtal_selected(xt),
    .osc_start_cycles(osc), .adc_enabled(adc), .timer2_async_select(as2),
    .global_irq_en(gie), .irq_pending_any(irq), .adc_done_irq(1'b0),
    .ext_irq_line_a(lva), .ext_irq_line_b(1'b0), .ext_level_en(lven),
    .two_wire_addr_hit(1'b0), .timer2_irq(1'b0), .timer2_ovf_ev(ovf),
    .timer2_cmp_ev(ovf), .timer2_ovf_ie(gie), .timer2_cmp_ie(gie),
    .store_ready_irq(1'b0), .wake_reset(wrst), .clk_core_en(ce),
    .clk_flash_en(fe), .clk_io_en(ie), .clk_adc_en(ae), .clk_async_en(ye),
    .main_osc_en(me), .timer_osc_en(te), .adc_start(ast), .asleep(slp),
    .reset_vector(rv), .irq_resume(ir));
  task chk(input logic [6:0] got, input logic [6:0] exp, input string msg);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("MISMATCH %0t %s", $time, msg);
      end
    end
  endtask
  task go(input [2:0] k, input a);
    begin
      @(negedge clk);
      kind = k;
      arm = a;
      sx = 1'b1;
      @(negedge clk);
      sx = 1'b0;
    end
  endtask
  task wait_wake(input want_irq);
    begin
      n = 0;
      while (!(ir | rv) && n < 40) begin
        @(negedge clk);
        n = n + 1;
      end
      chk(n < 40, 1'b1, "wake timeout");
      chk(ir, want_irq, "wrong resume kind");
      chk(rv, !want_irq, "wrong vector kind");
      chk({ce, fe, ie, ae, ye, me, te}, 7'h7F, "clocks after wake");
      chk(slp, 1'b0, "still asleep");
      lva = 1'b0;
      ovf = 1'b0;
      wrst = 1'b0;
    end
  endtask
  task tally_and_finish;
    begin
      if (fail_count == 0 && checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      fail_count = fail_count + 1;
      tally_and_finish;
    end
  end
  initial begin
    km = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
    ev = '{7'h1F, 7'h0F, 7'h00, 7'h05, 7'h02};
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    for (i = 4; i < 6; i = i + 1) begin
      go(i[2:0], 1'b1);
      chk(slp, 1'b0, "reserved code slept");
    end
    go(3'h0, 1'b0);
    chk(slp, 1'b0, "slept unarmed");
    xt = 1'b0;
    go(3'h6, 1'b1);
    chk(slp, 1'b0, "standby without crystal");
    xt = 1'b1;
    for (i = 0; i < 5; i = i + 1) begin
      go(km[i], 1'b1);
      chk(slp, 1'b1, "not asleep");
      chk({ce, fe, ie, ae, ye, me, te}, ev[i], "sleep enables");
      chk(ast, i < 2, "adc start");
      if (i == 0 || i == 2) begin
        fire = 1'b1;
        @(negedge clk);
        fire = 1'b0;
      end
      if (i == 2) begin
        repeat (8) @(negedge clk);
        chk(slp, 1'b1, "plain irq woke power-down");
      end
      lva = (i == 2);
      ovf = (i == 3);
      wrst = (i == 1 || i == 4);
      wait_wake(i == 0 || i == 2 || i == 3);
    end
    tally_and_finish;
  end
endmodule
